// ===== pkg/ulsi_regs.svh
`ifndef ULSI_REGS_SVH
`define ULSI_REGS_SVH

// line status field positions
`define ULSI_LS_READY      0
`define ULSI_LS_OVERRUN    1
`define ULSI_LS_PARITY     2
`define ULSI_LS_FRAMING    3
`define ULSI_LS_BREAK      4
`define ULSI_LS_TX_EMPTY   5
`define ULSI_LS_TX_IDLE    6
`define ULSI_LS_DATA_ERR   7

// interrupt enable field positions
`define ULSI_IE_RX_DATA    0
`define ULSI_IE_TX_EMPTY   1
`define ULSI_IE_RX_STATUS  2
`define ULSI_IE_MODEM      3
`define ULSI_IE_SLEEP      4
`define ULSI_IE_SPECIAL    5
`define ULSI_IE_RTS        6
`define ULSI_IE_CTS        7
`define ULSI_IE_RESET      8'h00

// interrupt identification codes and fields
`define ULSI_ID_NONE       6'h01
`define ULSI_ID_RX_STATUS  6'h06
`define ULSI_ID_RX_DATA    6'h04
`define ULSI_ID_TIMEOUT    6'h0c
`define ULSI_ID_TX_EMPTY   6'h02
`define ULSI_ID_MODEM      6'h00
`define ULSI_ID_SPECIAL    6'h10
`define ULSI_ID_HANDSHAKE  6'h20
`define ULSI_ID_PENDING_N  0
`define ULSI_ID_DEPTH_BIT  5

// sticky flag indices
`define ULSI_F_OVR         0
`define ULSI_F_PAR         1
`define ULSI_F_FRM         2
`define ULSI_F_BRK         3
`define ULSI_F_DERR        4
`define ULSI_F_TXE         5
`define ULSI_F_LV5         6
`define ULSI_F_RTS         7
`define ULSI_F_CTS         8
`define ULSI_FLAG_COUNT    9

// receive timeout in character periods
`define ULSI_TIMEOUT_CHARS 3'h4

// register select and break state encodings
`define ULSI_SEL_LS        3'h1
`define ULSI_SEL_IE        3'h2
`define ULSI_SEL_ID        3'h4
`define ULSI_BRK_IDLE      2'h1
`define ULSI_BRK_WAIT      2'h2

`endif

// ===== pkg/ulsi_pkg.sv
`include "ulsi_regs.svh"

package ulsi_pkg;

    // register selected by the host register port
    typedef enum logic [2:0] {
        SEL_LINE_STATUS = `ULSI_SEL_LS,
        SEL_INT_ENABLE  = `ULSI_SEL_IE,
        SEL_INT_ID      = `ULSI_SEL_ID
    } ulsi_reg_sel_type;

    // break hold-off state
    typedef enum logic [1:0] {
        BRK_IDLE = `ULSI_BRK_IDLE,
        BRK_WAIT = `ULSI_BRK_WAIT
    } ulsi_brk_type;

    // channel configuration from the mode registers
    typedef struct packed {
        logic enhanced;
        logic mode750;
        logic fifo128;
        logic nineBit;
        logic byteMode;
        logic fifoMode;
        logic inBandFlowEn;
        logic secondStopEn;
    } ulsi_cfg_type;

    // error and ninth-bit tags carried with a received item
    typedef struct packed {
        logic parity;
        logic framing;
        logic brk;
        logic ninth;
    } ulsi_rx_tag_type;

    // state of the main module, apart from the sticky flags held in ulsi_sticky_flags
    typedef struct packed {
        logic [7:0]   interrupt_enable;
        logic [7:0]   rdData;
        logic [2:0]   toCnt;
        logic         toPend;
        logic         txBelowPrev;
        ulsi_brk_type brk;
        logic         resync;
        logic         sinMeta;
        logic         sinSync;
    } ulsi_state_type;

endpackage

// ===== logic/ulsi_sticky_flags.sv
`timescale 1ns/1ps

module ulsi_sticky_flags #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // per-flag set and clear
    input  wire logic [WIDTH-1:0] flagSet,
    input  wire logic [WIDTH-1:0] flagClr,
    // flag values
    output logic      [WIDTH-1:0] flagQ
);

    logic [WIDTH-1:0] flag_reg;
    logic [WIDTH-1:0] flag_next;

    // set wins over a clear in the same cycle
    always_comb begin
        flag_next = (flag_reg & ~flagClr) | flagSet;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flagQ = flag_reg;

    // a set is never lost to a simultaneous clear
    a_set_wins_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (|(flagSet & flagClr)) |=> ((flagQ & $past(flagSet & flagClr)) == $past(flagSet & flagClr)))
        else $error("sticky flag lost a set to a clear");

endmodule

// ===== logic/ulsi_line_status_int.sv
`timescale 1ns/1ps
`include "ulsi_regs.svh"
// Contract
// - line status bit 0 shows receive queue not empty.
// - overrun set when a character meets a full queue; that character dropped.
// - parity flag set when bad item reaches head, cleared by status read.
// - in nine-bit framing bit 2 shows head item's ninth bit.
// - framing flag like parity; framing error restarts receiver on bad sample.
// - break loads one zero tagged item, then waits for input high.
// - bit 5 transmit queue empty; bit 6 queue and shifter empty, idle.
// - data error bit zero in byte mode, else set on bad entry, read-cleared.
// - in nine-bit framing data error ignores the ninth bit.
// - interrupt gated by global mask and enables, not by modem control.
// - enable bits 0..3 gate data, transmit empty, receiver status, modem.
// - nine-bit framing with enable 2: address bit raises level 1.
// - enable bit 4 requests sleep.
// - nine-bit framing with enable 5: special character raises level 5.
// - enhanced non-nine-bit: enable 5 arms stop character detections.
// - non-enhanced 750 mode without nine-bit framing: enable 5 is alternate sleep request.
// - enables 6 and 7 mask handshake changes only in enhanced mode.
// - identification shows only highest pending source, level 1 highest.
// - fixed six-bit codes per source.
// - identification bit 0 reads 1 when nothing pending.
// - levels 5 and 6 only in enhanced mode.
// - identification bit 5 code in 650/950, depth in 750, else 0.
// - data available active while fill level exceeds trigger.
// - timeout after four quiet character periods with data, FIFO mode.
// - transmit empty cleared by reporting read or fill above trigger.
// - modem change active while any modem delta flag set.

module ulsi_line_status_int
    import ulsi_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // host register port
    input  wire logic             regRead,
    input  wire logic             regWrite,
    input  wire ulsi_reg_sel_type regSel,
    input  wire logic [7:0]       regWrData,
    output logic      [7:0]       regRdData,
    // channel configuration
    input  wire ulsi_cfg_type     cfg,
    // receiver and receive queue
    input  wire logic             rxCharDone,
    input  wire ulsi_rx_tag_type  rxTag,
    input  wire logic             rxQueueFull,
    input  wire logic             rxQueueNotEmpty,
    input  wire logic             rxRead,
    input  wire logic             headLoad,
    input  wire ulsi_rx_tag_type  headTag,
    input  wire logic             rxAboveTrigger,
    input  wire logic             rxStopCentre,
    input  wire logic             charTick,
    input  wire logic             serialIn,
    output logic                  rxQueueWrite,
    output logic                  rxResyncStart,
    // transmitter
    input  wire logic             txQueueEmpty,
    input  wire logic             txShiftEmpty,
    input  wire logic             txBelowTrigger,
    // modem and special events
    input  wire logic [3:0]       modemDelta,
    input  wire logic             specialMatch,
    input  wire logic             xoffMatch,
    input  wire logic             xoff2Match,
    input  wire logic             rtsRise,
    input  wire logic             ctsRise,
    // interrupt and power
    input  wire logic             globalIntEnable,
    output logic                  irqOut,
    output logic                  sleepRequest,
    output logic                  xoffDetectEn,
    output logic                  xoff2DetectEn,
    output logic                  specialDetectEn
);

    localparam ulsi_state_type STATE_RESET = '{
        interrupt_enable:         `ULSI_IE_RESET,
        rdData:      8'h00,
        toCnt:       3'h0,
        toPend:      1'b0,
        txBelowPrev: 1'b0,
        brk:         BRK_IDLE,
        resync:      1'b0,
        sinMeta:     1'b1,
        sinSync:     1'b1
    };

    ulsi_state_type              st_reg;
    ulsi_state_type              st_next;
    logic [`ULSI_FLAG_COUNT-1:0] flagSet;
    logic [`ULSI_FLAG_COUNT-1:0] flagClr;
    logic [`ULSI_FLAG_COUNT-1:0] flag;
    logic [7:0]                  lineStatus;
    logic [7:0]                  intId;
    logic [5:0]                  idCode;
    logic                        lsrRead;
    logic                        idRead;
    logic                        ierWrite;
    logic                        rxErrTag;
    logic                        lvl1;
    logic                        lvl2a;
    logic                        lvl2b;
    logic                        lvl3;
    logic                        lvl4;
    logic                        lvl5;
    logic                        lvl6;
    logic                        rtsEn;
    logic                        ctsEn;
    logic                        depthBit;

    // register port decode
    always_comb begin
        lsrRead  = 1'b0;
        idRead   = 1'b0;
        ierWrite = 1'b0;
        if (regSel == SEL_LINE_STATUS) begin
            lsrRead = regRead;
        end else if (regSel == SEL_INT_ID) begin
            idRead = regRead;
        end else if (regSel == SEL_INT_ENABLE) begin
            ierWrite = regWrite;
        end
    end

    // queue write drops characters on full queue and during break hold-off
    assign rxQueueWrite = rxCharDone && !rxQueueFull && (st_reg.brk != BRK_WAIT);
    assign rxErrTag     = (rxTag.parity && !cfg.nineBit) || rxTag.framing || rxTag.brk;

    // sticky flag set and clear terms
    always_comb begin
        flagSet = '0;
        flagClr = '0;
        flagSet[`ULSI_F_OVR]  = rxCharDone && rxQueueFull && (st_reg.brk != BRK_WAIT);
        flagSet[`ULSI_F_PAR]  = headLoad && headTag.parity && !cfg.nineBit;
        flagSet[`ULSI_F_FRM]  = headLoad && headTag.framing;
        flagSet[`ULSI_F_BRK]  = headLoad && headTag.brk;
        flagSet[`ULSI_F_DERR] = rxQueueWrite && rxErrTag && !cfg.byteMode;
        flagSet[`ULSI_F_TXE]  = txBelowTrigger && !st_reg.txBelowPrev;
        flagSet[`ULSI_F_LV5]  = cfg.enhanced && st_reg.interrupt_enable[`ULSI_IE_SPECIAL] &&
            ((cfg.nineBit && specialMatch) ||
             (xoffDetectEn && xoffMatch) || (xoff2DetectEn && xoff2Match));
        flagSet[`ULSI_F_RTS]  = rtsRise;
        flagSet[`ULSI_F_CTS]  = ctsRise;
        flagClr[`ULSI_F_OVR]  = lsrRead;
        flagClr[`ULSI_F_PAR]  = lsrRead;
        flagClr[`ULSI_F_FRM]  = lsrRead;
        flagClr[`ULSI_F_BRK]  = lsrRead;
        flagClr[`ULSI_F_DERR] = lsrRead;
        flagClr[`ULSI_F_TXE]  = (idRead && (idCode == `ULSI_ID_TX_EMPTY)) || !txBelowTrigger;
        flagClr[`ULSI_F_LV5]  = idRead && (idCode == `ULSI_ID_SPECIAL);
        flagClr[`ULSI_F_RTS]  = idRead && (idCode == `ULSI_ID_HANDSHAKE);
        flagClr[`ULSI_F_CTS]  = idRead && (idCode == `ULSI_ID_HANDSHAKE);
    end

    // sticky flags, set wins over clear
    ulsi_sticky_flags #(
        .WIDTH (`ULSI_FLAG_COUNT)
    ) u_flags (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .flagSet  (flagSet),
        .flagClr  (flagClr),
        .flagQ    (flag)
    );

    // line status view
    always_comb begin
        lineStatus = 8'h00;
        lineStatus[`ULSI_LS_READY]    = rxQueueNotEmpty;
        lineStatus[`ULSI_LS_OVERRUN]  = flag[`ULSI_F_OVR];
        lineStatus[`ULSI_LS_PARITY]   = cfg.nineBit ? headTag.ninth : flag[`ULSI_F_PAR];
        lineStatus[`ULSI_LS_FRAMING]  = flag[`ULSI_F_FRM];
        lineStatus[`ULSI_LS_BREAK]    = flag[`ULSI_F_BRK];
        lineStatus[`ULSI_LS_TX_EMPTY] = txQueueEmpty;
        lineStatus[`ULSI_LS_TX_IDLE]  = txQueueEmpty && txShiftEmpty;
        lineStatus[`ULSI_LS_DATA_ERR] = flag[`ULSI_F_DERR] && !cfg.byteMode;
    end

    // source levels after enables
    assign rtsEn = cfg.enhanced ? st_reg.interrupt_enable[`ULSI_IE_RTS] : 1'b1;
    assign ctsEn = cfg.enhanced ? st_reg.interrupt_enable[`ULSI_IE_CTS] : 1'b1;
    assign lvl1  = st_reg.interrupt_enable[`ULSI_IE_RX_STATUS] &&
        (|lineStatus[`ULSI_LS_BREAK:`ULSI_LS_OVERRUN]);
    assign lvl2a = st_reg.interrupt_enable[`ULSI_IE_RX_DATA] && rxAboveTrigger;
    assign lvl2b = st_reg.interrupt_enable[`ULSI_IE_RX_DATA] && st_reg.toPend;
    assign lvl3  = st_reg.interrupt_enable[`ULSI_IE_TX_EMPTY] && flag[`ULSI_F_TXE];
    assign lvl4  = st_reg.interrupt_enable[`ULSI_IE_MODEM] && (|modemDelta);
    assign lvl5  = cfg.enhanced && st_reg.interrupt_enable[`ULSI_IE_SPECIAL] && flag[`ULSI_F_LV5];
    assign lvl6  = cfg.enhanced &&
        ((rtsEn && flag[`ULSI_F_RTS]) || (ctsEn && flag[`ULSI_F_CTS]));

    // priority encoder, level 1 first
    always_comb begin
        if (lvl1) begin
            idCode = `ULSI_ID_RX_STATUS;
        end else if (lvl2a) begin
            idCode = `ULSI_ID_RX_DATA;
        end else if (lvl2b) begin
            idCode = `ULSI_ID_TIMEOUT;
        end else if (lvl3) begin
            idCode = `ULSI_ID_TX_EMPTY;
        end else if (lvl4) begin
            idCode = `ULSI_ID_MODEM;
        end else if (lvl5) begin
            idCode = `ULSI_ID_SPECIAL;
        end else if (lvl6) begin
            idCode = `ULSI_ID_HANDSHAKE;
        end else begin
            idCode = `ULSI_ID_NONE;
        end
    end

    // bit 5 depends on the compatibility mode
    assign depthBit = cfg.enhanced ? idCode[`ULSI_ID_DEPTH_BIT] : (cfg.mode750 && cfg.fifo128);
    assign intId    = {2'b00, depthBit, idCode[`ULSI_ID_DEPTH_BIT-1:0]};

    // interrupt output, modem control plays no part
    assign irqOut = !idCode[`ULSI_ID_PENDING_N] && globalIntEnable;

    // sleep and detector enables
    assign sleepRequest = st_reg.interrupt_enable[`ULSI_IE_SLEEP] ||
        (!cfg.enhanced && cfg.mode750 && !cfg.nineBit && st_reg.interrupt_enable[`ULSI_IE_SPECIAL]);
    assign xoffDetectEn    = cfg.enhanced && !cfg.nineBit &&
        st_reg.interrupt_enable[`ULSI_IE_SPECIAL] && cfg.inBandFlowEn;
    assign xoff2DetectEn   = cfg.enhanced && !cfg.nineBit &&
        st_reg.interrupt_enable[`ULSI_IE_SPECIAL] && cfg.secondStopEn;
    assign specialDetectEn = cfg.nineBit && st_reg.interrupt_enable[`ULSI_IE_SPECIAL];

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.sinMeta     = serialIn;
        st_next.sinSync     = st_reg.sinMeta;
        st_next.txBelowPrev = txBelowTrigger;
        st_next.resync      = rxCharDone && rxTag.framing;
        if (ierWrite) begin
            st_next.interrupt_enable = regWrData;
        end
        if (regRead) begin
            if (regSel == SEL_LINE_STATUS) begin
                st_next.rdData = lineStatus;
            end else if (regSel == SEL_INT_ENABLE) begin
                st_next.rdData = st_reg.interrupt_enable;
            end else if (regSel == SEL_INT_ID) begin
                st_next.rdData = intId;
            end else begin
                st_next.rdData = 8'h00;
            end
        end
        // receive timeout counter in character periods
        if (rxQueueWrite || rxRead || rxStopCentre || !rxQueueNotEmpty) begin
            st_next.toCnt  = 3'h0;
            st_next.toPend = 1'b0;
        end else if (st_reg.toCnt == `ULSI_TIMEOUT_CHARS) begin
            st_next.toPend = cfg.fifoMode;
        end else if (charTick) begin
            st_next.toCnt = st_reg.toCnt + 3'h1;
        end
        // break hold-off until the line returns high
        case (st_reg.brk)
            BRK_IDLE: begin
                if (rxQueueWrite && rxTag.brk) begin
                    st_next.brk = BRK_WAIT;
                end
            end
            BRK_WAIT: begin
                if (st_reg.sinSync) begin
                    st_next.brk = BRK_IDLE;
                end
            end
            default: begin
                st_next.brk = BRK_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdData     = st_reg.rdData;
    assign rxResyncStart = st_reg.resync;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence lsrReadSeq;
        lsrRead && !headLoad;
    endsequence

    sequence overrunSeq;
        rxCharDone && rxQueueFull && (st_reg.brk == BRK_IDLE);
    endsequence

    a_overrun_flag: assert property (overrunSeq |-> !rxQueueWrite ##1 lineStatus[1])
        else $error("overrun not flagged or character not dropped");
    a_ready_bit: assert property (lineStatus[0] == rxQueueNotEmpty)
        else $error("ready bit differs from queue state");
    a_framing_clear: assert property (lsrReadSeq |=> !lineStatus[3])
        else $error("framing flag survived status read");
    a_parity_nine: assert property (cfg.nineBit |-> (lineStatus[2] == headTag.ninth))
        else $error("bit 2 not ninth bit in nine-bit framing");
    a_tx_idle_bit: assert property (lineStatus[6] |-> lineStatus[5])
        else $error("idle shown with transmit queue not empty");
    a_data_err_byte: assert property (cfg.byteMode |-> !lineStatus[7])
        else $error("data error set in byte mode");
    a_irq_pending: assert property (irqOut == (globalIntEnable && !intId[0]))
        else $error("interrupt output disagrees with pending bit");
    a_no_high_levels: assert property (!cfg.enhanced |-> !idCode[5] && !idCode[4])
        else $error("level 5 or 6 raised outside enhanced mode");
    a_timeout_cause: assert property ($rose(st_reg.toPend) |->
        $past(st_reg.toCnt) == `ULSI_TIMEOUT_CHARS && $past(cfg.fifoMode))
        else $error("timeout without four quiet periods");
    a_sleep_alt: assert property ((!cfg.enhanced && cfg.mode750 && !cfg.nineBit &&
        st_reg.interrupt_enable[5]) |-> sleepRequest)
        else $error("alternate sleep not requested");
    a_break_hold: assert property ((rxQueueWrite && rxTag.brk) ##1 !st_reg.sinSync
        |=> !rxQueueWrite)
        else $error("character accepted while waiting out a break");

endmodule

// ===== tb/ulsi_host_model.sv
`timescale 1ns/1ps

module ulsi_host_model
    import ulsi_pkg::*;
(
    // clock
    input  wire logic             core_clk,
    // register port towards the channel
    output logic                  regRead,
    output logic                  regWrite,
    output ulsi_reg_sel_type      regSel,
    output logic      [7:0]       regWrData,
    input  wire logic [7:0]       regRdData
);
    // idle port at time zero
    initial begin
        regRead = 1'b0;
        regWrite = 1'b0;
        regSel = SEL_LINE_STATUS;
        regWrData = 8'h00;
    end

    // one-cycle write strobe, data scrambled once released
    task automatic wr(input ulsi_reg_sel_type sel, input logic [7:0] d);
        @(posedge core_clk) #1;
        regWrite = 1'b1;
        regSel = sel;
        regWrData = d;
        @(posedge core_clk) #1;
        regWrite = 1'b0;
        regWrData = ~d;
    endtask

    // one-cycle read strobe, data taken the cycle after
    task automatic rd(input ulsi_reg_sel_type sel, output logic [7:0] d);
        @(posedge core_clk) #1;
        regRead = 1'b1;
        regSel = sel;
        @(posedge core_clk) #1;
        regRead = 1'b0;
        d = regRdData;
    endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps

module tb_top
    import ulsi_pkg::*;
;
    logic             core_clk, sys_rst, rxCharDone, rxQueueFull, rxQueueNotEmpty;
    logic             headLoad, rxAboveTrigger, charTick, txQueueEmpty, txShiftEmpty;
    logic             txBelowTrigger, specialMatch, rtsRise, ctsRise, globalIntEnable;
    logic             serialIn, xoffMatch, xoff2Match;
    logic             regRead, regWrite, irqOut, sleepRequest, xoffDetectEn;
    logic             xoff2DetectEn, specialDetectEn, rxQueueWrite, rxResyncStart;
    logic [7:0]       regWrData, regRdData, rdv;
    logic [3:0]       modemDelta;
    ulsi_reg_sel_type regSel;
    ulsi_rx_tag_type  rxTag, headTag;
    ulsi_cfg_type     cfg;
    int               fail_count, n_tests, cyc;
    logic [7:0]       ierT [5] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h80};
    logic [7:0]       expT [5] = '{8'h04, 8'h02, 8'h00, 8'h10, 8'h20};

    // 20 MHz clock
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    ulsi_host_model u_ulsi_host_model (.core_clk(core_clk), .regRead(regRead),
        .regWrite(regWrite), .regSel(regSel), .regWrData(regWrData), .regRdData(regRdData));

    ulsi_line_status_int u_ulsi_line_status_int (.core_clk(core_clk), .sys_rst(sys_rst),
        .regRead(regRead), .regWrite(regWrite), .regSel(regSel), .regWrData(regWrData),
        .regRdData(regRdData), .cfg(cfg), .rxCharDone(rxCharDone), .rxTag(rxTag),
        .rxQueueFull(rxQueueFull), .rxQueueNotEmpty(rxQueueNotEmpty), .rxRead(1'b0),
        .headLoad(headLoad), .headTag(headTag), .rxAboveTrigger(rxAboveTrigger),
        .rxStopCentre(1'b0), .charTick(charTick), .serialIn(serialIn),
        .rxQueueWrite(rxQueueWrite), .rxResyncStart(rxResyncStart),
        .txQueueEmpty(txQueueEmpty), .txShiftEmpty(txShiftEmpty),
        .txBelowTrigger(txBelowTrigger), .modemDelta(modemDelta),
        .specialMatch(specialMatch), .xoffMatch(xoffMatch), .xoff2Match(xoff2Match),
        .rtsRise(rtsRise), .ctsRise(ctsRise), .globalIntEnable(globalIntEnable),
        .irqOut(irqOut), .sleepRequest(sleepRequest), .xoffDetectEn(xoffDetectEn),
        .xoff2DetectEn(xoff2DetectEn), .specialDetectEn(specialDetectEn));

    // count and report one comparison
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // register read followed by comparison
    task automatic rchk(input ulsi_reg_sel_type sel, input string nm, input logic [7:0] exp);
        u_ulsi_host_model.rd(sel, rdv);
        chk(nm, rdv, exp);
    endtask

    // step to just after the n-th next edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end

    // main sequence
    initial begin
        {rxCharDone, rxQueueFull, rxQueueNotEmpty, headLoad, rxAboveTrigger} = '0;
        {charTick, txBelowTrigger, specialMatch, rtsRise, ctsRise, xoffMatch, xoff2Match} = '0;
        {txQueueEmpty, txShiftEmpty, globalIntEnable, serialIn} = 4'hf;
        rxTag = '0;
        headTag = '0;
        modemDelta = 4'h0;
        cfg = '0;
        cfg.fifoMode = 1'b1;
        sys_rst = 1'b1;
        tick(12);
        sys_rst = 1'b0;
        rchk(SEL_INT_ENABLE, "ie reset", 8'h00);
        rchk(SEL_INT_ID, "id reset", 8'h01);
        rchk(SEL_LINE_STATUS, "ls reset", 8'h60);
        txShiftEmpty = 1'b0;
        rchk(SEL_LINE_STATUS, "ls shifter busy", 8'h20);
        txShiftEmpty = 1'b1;
        // overrun on full queue, character dropped
        rxQueueFull = 1'b1;
        rxCharDone = 1'b1;
        #1 chk("queue write on full", rxQueueWrite, 8'h00);
        tick(1);
        rxCharDone = 1'b0;
        rxQueueFull = 1'b0;
        u_ulsi_host_model.wr(SEL_INT_ENABLE, 8'h04);
        rchk(SEL_INT_ID, "id overrun", 8'h06);
        chk("irq overrun", irqOut, 8'h01);
        rchk(SEL_LINE_STATUS, "ls overrun", 8'h62);
        rchk(SEL_LINE_STATUS, "ls read cleared", 8'h60);
        // parity, framing, break at head; last pass in byte mode
        rxQueueNotEmpty = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cfg.byteMode = (i == 3);
            cfg.fifoMode = (i != 3);
            rxTag = (i == 3) ? 4'b1000 : (4'b1000 >> i);
            headTag = rxTag;
            {rxCharDone, headLoad} = 2'b11;
            #1 chk("queue write", rxQueueWrite, 8'h01);
            tick(1);
            {rxCharDone, headLoad} = 2'b00;
            chk("resync", rxResyncStart, {7'h0, i == 1});
            rchk(SEL_LINE_STATUS, "ls error", 8'h61 | (8'h04 << (i % 3)) | ((i == 3) ? 8'h00 : 8'h80));
            rchk(SEL_LINE_STATUS, "ls error cleared", 8'h61);
        end
        // a break holds off the next character, even on a full queue
        serialIn = 1'b0;
        rxTag = 4'b0010;
        tick(2);
        rxCharDone = 1'b1;
        tick(1);
        rxQueueFull = 1'b1;
        #1 chk("write in break", rxQueueWrite, 8'h00);
        tick(1);
        {rxCharDone, rxQueueFull, serialIn} = 3'h1;
        tick(3);
        rchk(SEL_LINE_STATUS, "ls no overrun", 8'h61);
        // nine-bit framing shows the address bit, no data error
        cfg = '0;
        cfg.fifoMode = 1'b1;
        cfg.nineBit = 1'b1;
        cfg.enhanced = 1'b1;
        rxTag = 4'b1001;
        headTag = 4'b1001;
        {rxCharDone, headLoad} = 2'b11;
        tick(1);
        {rxCharDone, headLoad} = 2'b00;
        rchk(SEL_LINE_STATUS, "ls ninth", 8'h65);
        rchk(SEL_LINE_STATUS, "ls ninth level", 8'h65);
        rchk(SEL_INT_ID, "id address bit", 8'h06);
        headTag = 4'b0000;
        headLoad = 1'b1;
        tick(1);
        headLoad = 1'b0;
        // five sources alone, each with its enable
        for (int i = 0; i < 5; i++) begin
            u_ulsi_host_model.wr(SEL_INT_ENABLE, ierT[i]);
            case (i)
                0: rxAboveTrigger = 1'b1;
                1: txBelowTrigger = 1'b1;
                2: modemDelta = 4'h1;
                3: specialMatch = 1'b1;
                default: {ctsRise, rtsRise} = 2'b11;
            endcase
            tick(1);
            {specialMatch, ctsRise, rtsRise} = 3'h0;
            tick(1);
            chk("irq pending", irqOut, 8'h01);
            chk("special detect", specialDetectEn, {7'h0, i == 3});
            globalIntEnable = 1'b0;
            #1 chk("irq masked", irqOut, 8'h00);
            rchk(SEL_INT_ID, "id source", expT[i]);
            globalIntEnable = 1'b1;
            {rxAboveTrigger, modemDelta} = 5'h00;
            rchk(SEL_INT_ID, "id cleared", 8'h01);
            txBelowTrigger = 1'b0;
        end
        // priority between data available and transmit empty
        u_ulsi_host_model.wr(SEL_INT_ENABLE, 8'h03);
        {rxAboveTrigger, txBelowTrigger} = 2'b11;
        rchk(SEL_INT_ID, "id priority", 8'h04);
        {rxAboveTrigger, txBelowTrigger} = 2'b00;
        // stop character detection and sleep in enhanced mode
        cfg.nineBit = 1'b0;
        cfg.inBandFlowEn = 1'b1;
        cfg.secondStopEn = 1'b1;
        u_ulsi_host_model.wr(SEL_INT_ENABLE, 8'h30);
        chk("xoff detect", xoffDetectEn, 8'h01);
        chk("second_stop_character detect", xoff2DetectEn, 8'h01);
        chk("sleep", sleepRequest, 8'h01);
        chk("special off", specialDetectEn, 8'h00);
        // each stop character raises level 5
        for (int i = 0; i < 2; i++) begin
            {xoffMatch, xoff2Match} = 2'b01 << i;
            tick(1);
            {xoffMatch, xoff2Match} = 2'b00;
            rchk(SEL_INT_ID, "id stop character", 8'h10);
        end
        // 750 mode: depth bit, alternate sleep, no handshake level
        cfg = '0;
        cfg.mode750 = 1'b1;
        cfg.fifo128 = 1'b1;
        cfg.fifoMode = 1'b1;
        u_ulsi_host_model.wr(SEL_INT_ENABLE, 8'ha0);
        chk("alt sleep", sleepRequest, 8'h01);
        {ctsRise, rtsRise} = 2'b11;
        tick(1);
        {ctsRise, rtsRise} = 2'b00;
        rchk(SEL_INT_ID, "id 750", 8'h21);
        // timeout after four quiet character periods
        u_ulsi_host_model.wr(SEL_INT_ENABLE, 8'h01);
        repeat (4) begin
            charTick = 1'b1;
            tick(1);
            charTick = 1'b0;
            tick(1);
        end
        tick(2);
        rchk(SEL_INT_ID, "id timeout", 8'h2c);
        test_done();
    end
endmodule
